// File: include/fdchp_pkg.sv
/*
 * Constants, types and decode helpers for the host command port of the disk controller.
 * Assumes one 20 MHz clock and a synchronous, active-high reset in every user.
 */
package fdchp_pkg;

	typedef logic [7:0] fdchp_byte_t;
	typedef enum logic [1:0] {PH_CMD, PH_EXEC, PH_RES} fdchp_phase_t;
	typedef enum logic [2:0] {
		OP_READ, OP_RDEL, OP_WRITE, OP_TRACK, OP_RDID, OP_FMT, OP_BAD
	} fdchp_op_t;

	// Main status bit positions.
	localparam int MSR_BUSY = 4;
	localparam int MSR_NDM = 5;
	localparam int MSR_DIO = 6;
	localparam int MSR_RQM = 7;
	localparam int DRIVES = 4;

	// Command byte fields and operation codes.
	localparam int FLAG_MT = 7;
	localparam int FLAG_SK = 5;
	localparam logic [4:0] CODE_READ = 5'h06;
	localparam logic [4:0] CODE_RDEL = 5'h0C;
	localparam logic [4:0] CODE_WRITE = 5'h05;
	localparam logic [4:0] CODE_TRACK = 5'h02;
	localparam logic [4:0] CODE_RDID = 5'h0A;
	localparam logic [4:0] CODE_FMT = 5'h0D;

	// Byte counts of each phase.
	localparam int CMD_MAX = 9;
	localparam int RES_MAX = 7;
	localparam logic [3:0] LEN_SECTOR = 4'h9;
	localparam logic [3:0] LEN_RDID = 4'h2;
	localparam logic [3:0] LEN_FMT = 4'h6;
	localparam logic [3:0] LEN_ONE = 4'h1;
	localparam logic [3:0] LEN_RES = 4'h7;
	localparam fdchp_byte_t ST0_INVALID = 8'h80;

	// Synchronised strobe vector {cs_n, rd_n, wr_n, register_select} while idle.
	localparam logic [3:0] CTL_IDLE = 4'hF;
	localparam int CTL_CS = 3;
	localparam int CTL_RD = 2;
	localparam int CTL_WR = 1;
	localparam int CTL_RS = 0;

	// Step timing.
	localparam int CLK_HZ = 20000000;
	localparam int STEP_UNIT_MS = 1;
	localparam int STEP_MAX_MS = 16;
	localparam int STEP_HIGH_US = 5;
	localparam int STEP_MS_CYC = CLK_HZ / 1000 * STEP_UNIT_MS;
	localparam int STEP_HIGH_CYC = CLK_HZ / 1000000 * STEP_HIGH_US;

	function automatic fdchp_op_t fdchp_decode(input fdchp_byte_t b);
		fdchp_op_t op;
		op = OP_BAD;
		unique case (b[4:0])
			CODE_READ: op = OP_READ;
			CODE_RDEL: op = OP_RDEL;
			CODE_WRITE: op = b[FLAG_SK] ? OP_BAD : OP_WRITE;
			CODE_TRACK: op = b[FLAG_MT] ? OP_BAD : OP_TRACK;
			CODE_RDID: op = (b[FLAG_MT] | b[FLAG_SK]) ? OP_BAD : OP_RDID;
			CODE_FMT: op = (b[FLAG_MT] | b[FLAG_SK]) ? OP_BAD : OP_FMT;
			default: op = OP_BAD;
		endcase
		return op;
	endfunction

	function automatic logic [3:0] fdchp_cmd_len(input fdchp_op_t op);
		logic [3:0] n;
		n = LEN_SECTOR;
		unique case (op)
			OP_RDID: n = LEN_RDID;
			OP_FMT: n = LEN_FMT;
			OP_BAD: n = LEN_ONE;
			default: n = LEN_SECTOR;
		endcase
		return n;
	endfunction

endpackage

// File: include/fdchp_step_if.sv
/*
 * Carrier between the command port and its step pulse generator.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
interface fdchp_step_if;
	logic step_req;
	logic [3:0] rate;
	logic step_out;
	logic busy;
	modport ctl(output step_req, output rate, input step_out, input busy);
	modport gen(input step_req, input rate, output step_out, output busy);
endinterface

// File: hw/fdchp_step.sv
/*
 * Step pulse generator: a high pulse at the start of a busy interval of whole milliseconds.
 * Assumes step requests come from logic on the same clock.
 */
`timescale 1ns/10ps
module fdchp_step #(
	parameter int MS_CYC = fdchp_pkg::STEP_MS_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	fdchp_step_if.gen sp
);
	import fdchp_pkg::*;

	typedef struct packed {
		logic active;
		logic pin;
		logic [23:0] pre;
		logic [4:0] ms_left;
	} fdchp_step_st_t;

	fdchp_step_st_t s;
	fdchp_step_st_t next_s;

	always_comb begin
		next_s = s;
		if (!s.active) begin
			if (sp.step_req) begin
				next_s.active = 1'b1;
				next_s.pin = 1'b1;
				next_s.pre = '0;
				// Code 0 gives the longest interval, code 15 the shortest.
				next_s.ms_left = 5'(STEP_MAX_MS) - {1'b0, sp.rate};
			end
		end else begin
			if (s.pre == 24'(STEP_HIGH_CYC - 1)) begin
				next_s.pin = 1'b0;
			end
			if (s.pre == 24'(MS_CYC - 1)) begin
				next_s.pre = '0;
				if (s.ms_left == 5'h01) begin
					next_s.active = 1'b0;
					next_s.pin = 1'b0;
				end else begin
					next_s.ms_left = s.ms_left - 5'h01;
				end
			end else begin
				next_s.pre = s.pre + 24'h000001;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s <= '0;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	assign sp.step_out = s.pin;
	assign sp.busy = s.active;
endmodule

// File: hw/fdchp_top.sv
/*
 * Processor-facing command port of a floppy disk controller: status register,
 * data byte stack, the three command phases and the step output.
 * Assumes bus pins are asynchronous to ref_clk and that drive-side engine
 * signals (drv_*, drive_seeking, non_dma_flag, step_req) share ref_clk.
 */
`timescale 1ns/10ps
module fdchp_top #(
	parameter int STEP_MS_CYC_P = fdchp_pkg::STEP_MS_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic register_select,
	input wire fdchp_pkg::fdchp_byte_t db_in,
	output fdchp_pkg::fdchp_byte_t db_out,
	output logic db_oe,
	input wire logic [3:0] drive_seeking,
	input wire logic non_dma_flag,
	input wire logic step_req,
	input wire logic [3:0] step_rate,
	output logic fault_reset_step_pin,
	output logic step_busy,
	output logic drv_start,
	output logic [71:0] drv_cmd,
	input wire fdchp_pkg::fdchp_byte_t drv_rd_data,
	input wire logic drv_rd_valid,
	output logic drv_rd_ready,
	output fdchp_pkg::fdchp_byte_t drv_wr_data,
	output logic drv_wr_valid,
	input wire logic drv_wr_ready,
	input wire logic drv_done,
	input wire logic [23:0] drv_status,
	input wire logic [31:0] drv_id
);
	import fdchp_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [3:0] sy1_ctl;
		logic [3:0] sy2_ctl;
		fdchp_byte_t sy1_db;
		fdchp_byte_t sy2_db;
		logic rd_on;
		logic wr_on;
		fdchp_byte_t wbyte;
		fdchp_phase_t phase;
		fdchp_op_t op;
		logic [3:0] cnt;
		logic [3:0] need;
		logic [CMD_MAX-1:0][7:0] cmd;
		logic [RES_MAX-1:0][7:0] res;
		fdchp_byte_t xfer;
		logic full;
		logic start;
		fdchp_byte_t dout;
		logic doe;
	} fdchp_state_t;

	fdchp_state_t s;
	fdchp_state_t next_s;

	fdchp_step_if sp();

	logic sel;
	logic rd;
	logic wr;
	logic rs;
	logic data_rd;
	logic data_wr;
	logic stat_rd;
	logic end_rd;
	logic end_wr;
	logic rd_type;
	logic wr_type;
	logic host_request_ready;
	logic transfer_direction;
	logic busy;
	fdchp_byte_t msr;
	fdchp_byte_t data_src;

	// ==========================================================
	// Bus decode
	// ==========================================================
	// Only the second synchroniser stage is looked at.
	assign sel = ~s.sy2_ctl[CTL_CS];
	assign rd = ~s.sy2_ctl[CTL_RD];
	assign wr = ~s.sy2_ctl[CTL_WR];
	assign rs = s.sy2_ctl[CTL_RS];
	assign stat_rd = sel & ~rs & rd & ~wr;
	assign data_rd = sel & rs & rd & ~wr;
	assign data_wr = sel & rs & wr & ~rd;
	// An access counts once its strobe is released cleanly.
	assign end_rd = s.rd_on & ~rd & ~wr;
	assign end_wr = s.wr_on & ~rd & ~wr;

	// ==========================================================
	// Status
	// ==========================================================
	assign rd_type = (s.op == OP_READ) | (s.op == OP_RDEL) | (s.op == OP_TRACK);
	assign wr_type = (s.op == OP_WRITE);

	always_comb begin
		host_request_ready = 1'b0;
		transfer_direction = 1'b0;
		unique case (s.phase)
			PH_CMD: begin
				host_request_ready = 1'b1;
			end
			PH_EXEC: begin
				host_request_ready = rd_type ? s.full : (wr_type & ~s.full);
				transfer_direction = rd_type;
			end
			PH_RES: begin
				host_request_ready = 1'b1;
				transfer_direction = 1'b1;
			end
		endcase
	end

	// The port is busy from the first command byte to the last result byte.
	assign busy = (s.phase != PH_CMD) | (s.cnt != 4'h0);

	genvar gi;
	generate
		for (gi = 0; gi < DRIVES; gi++) begin : g_seek
			assign msr[gi] = drive_seeking[gi];
		end
	endgenerate
	assign msr[MSR_BUSY] = busy;
	assign msr[MSR_NDM] = non_dma_flag;
	assign msr[MSR_DIO] = transfer_direction;
	assign msr[MSR_RQM] = host_request_ready;

	// Only one byte of the stack is ever presented.
	always_comb begin
		data_src = s.xfer;
		if (s.phase == PH_RES) begin
			data_src = s.res[s.cnt[2:0]];
		end
	end

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		fdchp_op_t op_now;
		logic [3:0] len_now;
		logic [3:0] cnt_inc;
		op_now = s.op;
		len_now = s.need;
		cnt_inc = 4'(s.cnt + 4'h1);
		next_s = s;
		next_s.start = 1'b0;
		next_s.sy1_ctl = {cs_n, rd_n, wr_n, register_select};
		next_s.sy2_ctl = s.sy1_ctl;
		next_s.sy1_db = db_in;
		next_s.sy2_db = s.sy1_db;

		// A data access only starts when ready in its own direction; a host
		// that skips the handshake is simply ignored.
		next_s.rd_on = data_rd & (s.rd_on | (host_request_ready & transfer_direction));
		next_s.wr_on = data_wr & (s.wr_on | (host_request_ready & ~transfer_direction));
		if (data_wr) begin
			next_s.wbyte = s.sy2_db;
		end

		// Status reads touch nothing but the output register.
		next_s.doe = stat_rd | next_s.rd_on;
		next_s.dout = stat_rd ? msr : data_src;

		// Host writes: command bytes, or sector data during a write.
		if (end_wr) begin
			unique case (s.phase)
				PH_CMD: begin
					next_s.cmd[s.cnt] = s.wbyte;
					if (s.cnt == 4'h0) begin
						op_now = fdchp_decode(s.wbyte);
						len_now = fdchp_cmd_len(op_now);
						next_s.op = op_now;
						next_s.need = len_now;
					end
					next_s.cnt = cnt_inc;
					if (op_now == OP_BAD) begin
						next_s.phase = PH_RES;
						next_s.cnt = 4'h0;
						next_s.res[0] = ST0_INVALID;
					end else if (cnt_inc == len_now) begin
						next_s.phase = PH_EXEC;
						next_s.cnt = 4'h0;
						next_s.start = 1'b1;
						next_s.full = 1'b0;
					end
				end
				PH_EXEC: begin
					if (wr_type) begin
						next_s.xfer = s.wbyte;
						next_s.full = 1'b1;
					end
				end
				PH_RES: begin
					next_s.phase = s.phase;
				end
			endcase
		end

		// Host reads: sector data during a read, then the result bytes.
		if (end_rd) begin
			unique case (s.phase)
				PH_EXEC: begin
					next_s.full = 1'b0;
				end
				PH_RES: begin
					if (cnt_inc == ((s.op == OP_BAD) ? LEN_ONE : LEN_RES)) begin
						next_s.phase = PH_CMD;
						next_s.cnt = 4'h0;
						next_s.need = 4'h0;
					end else begin
						next_s.cnt = cnt_inc;
					end
				end
				PH_CMD: begin
					next_s.phase = s.phase;
				end
			endcase
		end

		// Drive engine side of the execution phase.
		if (s.phase == PH_EXEC) begin
			if (rd_type & ~s.full & drv_rd_valid) begin
				next_s.xfer = drv_rd_data;
				next_s.full = 1'b1;
			end
			if (wr_type & s.full & drv_wr_ready) begin
				next_s.full = 1'b0;
			end
			// Read-ID returns the first good identifier; after format the
			// identifier bytes pass through but mean nothing.
			if (drv_done) begin
				next_s.phase = PH_RES;
				next_s.cnt = 4'h0;
				next_s.full = 1'b0;
				next_s.res = {drv_id, drv_status};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.sy1_ctl <= CTL_IDLE;
			s.sy2_ctl <= CTL_IDLE;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Step output
	// ==========================================================
	assign sp.step_req = step_req;
	assign sp.rate = step_rate;

	fdchp_step #(
		.MS_CYC(STEP_MS_CYC_P)
	) u_step (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sp(sp)
	);

	assign fault_reset_step_pin = sp.step_out;
	assign step_busy = sp.busy;

	// ==========================================================
	// Outputs
	// ==========================================================
	assign db_out = s.dout;
	assign db_oe = s.doe;
	assign drv_start = s.start;
	// Byte 0 (opcode) sits in the low byte; read-track, read-ID and format
	// parameters are interpreted by the drive engine.
	assign drv_cmd = s.cmd;
	assign drv_rd_ready = (s.phase == PH_EXEC) & rd_type & ~s.full;
	assign drv_wr_data = s.xfer;
	assign drv_wr_valid = (s.phase == PH_EXEC) & wr_type & s.full;
endmodule

// File: sim/fdchp_monitor.sv
/*
 * Checker on the command port pins: bus answers, start pulse and step timing.
 * Assumes one clock and a synchronous active-high reset; bound into fdchp_top.
 */
`timescale 1ns/10ps
module fdchp_monitor #(
	parameter int STEP_MS_CYC_P = fdchp_pkg::STEP_MS_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic register_select,
	input wire fdchp_pkg::fdchp_byte_t db_out,
	input wire logic db_oe,
	input wire logic [3:0] drive_seeking,
	input wire logic non_dma_flag,
	input wire logic [3:0] step_rate,
	input wire logic fault_reset_step_pin,
	input wire logic step_busy,
	input wire logic drv_start
);
	import fdchp_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	int hi_cnt;
	int bz_cnt;
	logic [3:0] rate_q;
	// ==========
	// Helper counters
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hi_cnt <= 0;
			bz_cnt <= 0;
			rate_q <= 4'h0;
		end else begin
			hi_cnt <= fault_reset_step_pin ? hi_cnt + 1 : 0;
			bz_cnt <= step_busy ? bz_cnt + 1 : 0;
			rate_q <= step_busy ? rate_q : step_rate;
		end
	end
	// ==========
	// Properties
	sequence s_start_pulse;
		drv_start ##1 !drv_start;
	endsequence
	// Inputs held still for three cycles, so the synchronised copy matches them.
	sequence s_status_shown;
		db_oe && $past(!register_select, 3) && $past(!register_select, 4)
			&& $past(drive_seeking, 3) == drive_seeking && $past(non_dma_flag, 3) == non_dma_flag;
	endsequence
	property p_reset_quiet;
		$fell(sys_rst) |-> !db_oe && !drv_start && !fault_reset_step_pin && !step_busy;
	endproperty
	property p_oe_cause;
		$rose(db_oe) |-> $past(!cs_n && !rd_n && wr_n, 3);
	endproperty
	property p_write_silent;
		$past(!cs_n && !wr_n, 3) |-> !$rose(db_oe);
	endproperty
	property p_oe_release;
		$rose(rd_n) |-> ##3 !db_oe;
	endproperty
	property p_status_live;
		s_status_shown |-> db_out[3:0] == drive_seeking && db_out[MSR_NDM] == non_dma_flag;
	endproperty
	property p_start_pulse;
		drv_start |-> $past(wr_n) ##0 s_start_pulse;
	endproperty
	property p_step_pulse;
		$fell(fault_reset_step_pin) |-> hi_cnt == STEP_HIGH_CYC;
	endproperty
	property p_step_interval;
		$fell(step_busy) |-> bz_cnt == (16 - rate_q) * STEP_MS_CYC_P;
	endproperty
	property p_pin_in_busy;
		fault_reset_step_pin |-> step_busy;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven without a read");
	a_write_silent: assert property (p_write_silent) else $error("bus driven on a write");
	a_oe_release: assert property (p_oe_release) else $error("bus held after read end");
	a_status_live: assert property (p_status_live) else $error("status bits stale");
	a_start_pulse: assert property (p_start_pulse) else $error("bad start pulse");
	a_step_pulse: assert property (p_step_pulse) else $error("step pulse width wrong");
	a_step_interval: assert property (p_step_interval) else $error("step interval wrong");
	a_pin_in_busy: assert property (p_pin_in_busy) else $error("step pulse outside interval");
endmodule
bind fdchp_top fdchp_monitor #(.STEP_MS_CYC_P(STEP_MS_CYC_P)) u_monitor (.ref_clk, .sys_rst,
	.cs_n, .rd_n, .wr_n, .register_select, .db_out, .db_oe, .drive_seeking, .non_dma_flag,
	.step_rate, .fault_reset_step_pin, .step_busy, .drv_start);

// File: sim/fdchp_host_model.sv
/*
 * Host processor model on the 8-bit strobe bus of the command port.
 * Assumes the bench clock; pins change on the falling edge only.
 */
`timescale 1ns/10ps
module fdchp_host_model (
	input wire logic ref_clk,
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic register_select,
	output fdchp_pkg::fdchp_byte_t db_in,
	input wire fdchp_pkg::fdchp_byte_t db_out,
	input wire logic db_oe
);
	import fdchp_pkg::*;
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		register_select = 1'b0;
		db_in = 8'h00;
	end
	// ==========
	// Bus cycles
	// Strobes stay low six cycles, exactly the 300 ns minimum and well past the sync delay.
	task automatic cycle(input logic rs, input logic rdn, input logic wrn,
			input fdchp_byte_t d, output fdchp_byte_t q);
		@(negedge ref_clk);
		cs_n = 1'b0;
		register_select = rs;
		rd_n = rdn;
		wr_n = wrn;
		db_in = d;
		repeat (6) @(negedge ref_clk);
		q = (db_oe === 1'b1) ? db_out : 8'hXX;
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		db_in = ~d;
		repeat (6) @(negedge ref_clk);
	endtask
	task automatic status(output fdchp_byte_t q);
		cycle(1'b0, 1'b0, 1'b1, 8'h00, q);
	endtask
	task automatic wait_ready(input logic dir);
		fdchp_byte_t s;
		int n;
		n = 0;
		do begin
			status(s);
			n++;
		end while ((s[MSR_RQM] !== 1'b1 || s[MSR_DIO] !== dir) && n < 40);
	endtask
	task automatic put(input fdchp_byte_t d);
		fdchp_byte_t q;
		wait_ready(1'b0);
		cycle(1'b1, 1'b1, 1'b0, d, q);
	endtask
	task automatic get(output fdchp_byte_t q);
		wait_ready(1'b1);
		cycle(1'b1, 1'b0, 1'b1, 8'h00, q);
	endtask
endmodule

// File: sim/disk_ctrl_host_command_port_tb_top.sv
/*
 * Bench for the command port: reset, refusals, each command, step timing.
 * Assumes the package, design, checker and host model are compiled first.
 */
`timescale 1ns/10ps
`define FDCHP_CHECK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) begin \
			failures++; \
			$display("Error at %0t: got %h, expected %h", $time, (got), (exp)); \
		end \
	end
module disk_ctrl_host_command_port_tb_top;
	import fdchp_pkg::*;
	localparam int MS = 200;
	localparam int RATE = 14;
	localparam fdchp_byte_t OPC [6] = '{8'hE6, 8'h4C, 8'hC5, 8'h62, 8'h4A, 8'h4D};
	localparam int LEN [6] = '{9, 9, 9, 9, 2, 6};
	localparam int DIR [6] = '{1, 1, 2, 1, 0, 0};
	localparam fdchp_byte_t BAD [3] = '{8'h1F, 8'h25, 8'h82};
	localparam logic [55:0] RES_ALL = 56'h02051127B2B1B0;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [3:0] drive_seeking = 4'hA;
	logic [3:0] step_rate = 4'(RATE);
	logic non_dma_flag = 1'b1;
	logic step_req = 1'b0;
	logic drv_rd_valid = 1'b0;
	logic drv_wr_ready = 1'b0;
	logic drv_done = 1'b0;
	fdchp_byte_t drv_rd_data = 8'h00;
	logic [23:0] drv_status = RES_ALL[23:0];
	logic [31:0] drv_id = RES_ALL[55:24];
	logic cs_n, rd_n, wr_n, register_select, db_oe, fault_reset_step_pin, step_busy;
	logic drv_start, drv_rd_ready, drv_wr_valid;
	fdchp_byte_t db_in, db_out, drv_wr_data, q;
	logic [71:0] drv_cmd;
	int failures = 0;
	int samples_checked = 0;
	int starts = 0;
	int n0, w, hi, bz;
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (drv_start === 1'b1) starts++;
	end
	fdchp_top #(.STEP_MS_CYC_P(MS)) u_dut (.ref_clk, .sys_rst, .clk_en, .cs_n, .rd_n, .wr_n,
		.register_select, .db_in, .db_out, .db_oe, .drive_seeking, .non_dma_flag, .step_req,
		.step_rate, .fault_reset_step_pin, .step_busy, .drv_start, .drv_cmd, .drv_rd_data,
		.drv_rd_valid, .drv_rd_ready, .drv_wr_data, .drv_wr_valid, .drv_wr_ready, .drv_done,
		.drv_status, .drv_id);
	fdchp_host_model u_host (.ref_clk, .cs_n, .rd_n, .wr_n, .register_select, .db_in, .db_out,
		.db_oe);
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ==========
	// Watchdog, about six times the expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		report_and_stop();
	end
	// ==========
	// Tests
	initial begin
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		`FDCHP_CHECK(db_oe, 1'b0)
		u_host.status(q);
		`FDCHP_CHECK(q, 8'hAA)
		$display("Test reset done");
		foreach (BAD[i]) begin
			u_host.put(BAD[i]);
			u_host.status(q);
			`FDCHP_CHECK(q, 8'hFA)
			u_host.get(q);
			`FDCHP_CHECK(q, ST0_INVALID)
			u_host.status(q);
			`FDCHP_CHECK(q, 8'hAA)
		end
		$display("Test invalid codes done");
		for (int k = 0; k < 6; k++) begin
			n0 = starts;
			u_host.put(OPC[k]);
			if (k == 0) begin
				u_host.cycle(1'b0, 1'b1, 1'b0, 8'h5A, q);
				u_host.cycle(1'b1, 1'b0, 1'b0, 8'h5A, q);
				u_host.status(q);
				`FDCHP_CHECK(q, 8'hBA)
			end
			for (int j = 1; j < LEN[k]; j++) begin
				u_host.put(fdchp_byte_t'(16 * k + j));
			end
			`FDCHP_CHECK(starts, n0 + 1)
			`FDCHP_CHECK(drv_cmd[7:0], OPC[k])
			for (int j = 1; j < LEN[k]; j++) begin
				`FDCHP_CHECK(drv_cmd[8 * j +: 8], fdchp_byte_t'(16 * k + j))
			end
			w = 0;
			if (DIR[k] == 1) begin
				drv_rd_data = {4'hC, 4'(k)};
				drv_rd_valid = 1'b1;
				// Ready is looked at mid-cycle, so the byte moves at the next rising edge.
				while (drv_rd_ready !== 1'b1 && w < 50) begin
					@(negedge ref_clk);
					w++;
				end
				@(negedge ref_clk);
				drv_rd_valid = 1'b0;
				u_host.get(q);
				`FDCHP_CHECK(q, {4'hC, 4'(k)})
			end else if (DIR[k] == 2) begin
				u_host.put(8'h3C);
				while (drv_wr_valid !== 1'b1 && w < 50) begin
					@(negedge ref_clk);
					w++;
				end
				`FDCHP_CHECK(drv_wr_data, 8'h3C)
				drv_wr_ready = 1'b1;
				@(negedge ref_clk);
				drv_wr_ready = 1'b0;
			end else begin
				drive_seeking = 4'(k);
				u_host.status(q);
				`FDCHP_CHECK(q, {4'h3, 4'(k)})
				drive_seeking = 4'hA;
			end
			drv_done = 1'b1;
			@(negedge ref_clk);
			drv_done = 1'b0;
			for (int j = 0; j < RES_MAX; j++) begin
				u_host.get(q);
				`FDCHP_CHECK(q, RES_ALL[8 * j +: 8])
			end
			u_host.status(q);
			`FDCHP_CHECK(q, 8'hAA)
			$display("Test command %h done", OPC[k]);
		end
		hi = 0;
		bz = 0;
		step_req = 1'b1;
		repeat ((16 - RATE) * MS + 100) begin
			@(negedge ref_clk);
			step_req = 1'b0;
			hi += int'(fault_reset_step_pin === 1'b1);
			bz += int'(step_busy === 1'b1);
		end
		`FDCHP_CHECK(hi, STEP_HIGH_CYC)
		`FDCHP_CHECK(bz, (16 - RATE) * MS)
		$display("Test step done");
		report_and_stop();
	end
endmodule
